// ===== pcrb_top.sv
// pcrb_top: pump configuration registers and the pump logic they steer.
// assumes register port driven by a protocol front end on clk; all
// condition inputs are asynchronous pins and are synchronised here.
`default_nettype none

module pcrb_top
	import pcrb_pkg::*;
#(
	parameter int TICK_CYCLES = CYCLES_PER_SECOND,
	parameter int DAY_SECONDS = SECONDS_PER_DAY
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [15:0] reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [15:0] reg_wdata,
	output logic      [15:0] reg_rdata,
	output logic             reg_ack,
	output logic             reg_err,
	input  wire logic [1:0]  boiler_output_select,
	input  wire logic        boiler_forced_on,
	input  wire logic        boiler_demand,
	input  wire logic        system_demand,
	input  wire logic        aux1_demand,
	input  wire logic [2:0]  aux_pump_zyx,
	input  wire logic        domestic_hot_water_service,
	input  wire logic        space_heating_service,
	input  wire logic        domestic_hot_water_demand,
	input  wire logic        space_heating_demand,
	input  wire logic        local_burner_demand,
	input  wire logic        fault_present,
	input  wire logic        domestic_hot_water_high_limit,
	input  wire logic        domestic_hot_water_anti_cond,
	input  wire logic        space_heating_anti_cond,
	input  wire logic        domestic_hot_water_priority,
	input  wire logic        domestic_hot_water_frost,
	input  wire logic        space_heating_frost,
	input  wire logic        sequencing_slave_demand,
	input  wire logic        outlet_high_limit,
	output logic      [2:0]  pump_out,
	output logic      [2:0]  role_running,
	output logic             space_heating_pump_on,
	output logic             domestic_hot_water_pump_on,
	output logic             space_heating_pump_sequencing_use,
	output logic             exercise_active
);

	localparam int NROLE = 3;
	localparam int NSYNC = 21;

	// ---------------------------------------------------------------
	// pin synchronisers
	logic [NSYNC-1:0] sync1_ff;
	logic [NSYNC-1:0] sync2_ff;
	logic [NSYNC-1:0] raw_in;

	assign raw_in = {
		aux1_demand, system_demand, boiler_demand, boiler_forced_on,
		aux_pump_zyx, domestic_hot_water_service, space_heating_service,
		domestic_hot_water_demand, space_heating_demand,
		local_burner_demand, fault_present,
		domestic_hot_water_high_limit, domestic_hot_water_anti_cond,
		space_heating_anti_cond, domestic_hot_water_priority,
		domestic_hot_water_frost, space_heating_frost,
		sequencing_slave_demand, outlet_high_limit
	};

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end else begin
			sync1_ff <= raw_in;
			sync2_ff <= sync1_ff;
		end
	end

	logic [2:0] s_role_dem;
	logic       s_boiler_forced;
	logic [2:0] s_zyx;
	logic       s_hw_svc;
	logic       s_sh_svc;
	logic       s_hw_dem;
	logic       s_sh_dem;
	logic       s_local;
	logic       s_fault;
	logic [3:0] s_off_cond;
	logic [4:0] s_on_cond;

	assign s_role_dem      = sync2_ff[20:18];
	assign s_boiler_forced = sync2_ff[17];
	assign s_zyx           = sync2_ff[16:14];
	assign s_hw_svc        = sync2_ff[13];
	assign s_sh_svc        = sync2_ff[12];
	assign s_hw_dem        = sync2_ff[11];
	assign s_sh_dem        = sync2_ff[10];
	assign s_local         = sync2_ff[9];
	assign s_fault         = sync2_ff[8];
	assign s_off_cond      = sync2_ff[7:4];
	// force-on bit 1 reuses the local burner demand pin
	assign s_on_cond       = {sync2_ff[3:1], sync2_ff[9], sync2_ff[0]};

	// ---------------------------------------------------------------
	// register file
	logic [15:0] cfg_ff [REG_COUNT];
	logic        in_map;
	logic [3:0]  idx;
	logic [15:0] rel_addr;
	logic        is_reserved;

	assign in_map      = (reg_addr >= REG_FIRST) && (reg_addr <= REG_LAST);
	assign rel_addr    = reg_addr - REG_FIRST;
	assign idx         = rel_addr[3:0];
	assign is_reserved = (reg_addr == RESERVED_SLOT);

	function automatic logic [15:0] wr_mask(input logic [15:0] a);
		logic [15:0] m;
		m = 16'hffff;
		case (a)
			// [RULE_10] demand reserved bits
			HEATING_PUMP_DEMAND_OPTIONS,
			HOT_WATER_PUMP_DEMAND_OPTIONS: m = DEMAND_OPT_MASK;
			// [RULE_15] override reserved bits
			HEATING_PUMP_OVERRIDE_OPTIONS: m = OVERRIDE_OPT_MASK;
			RESERVED_SLOT:                 m = 16'h0000;
			default:                       m = 16'hffff;
		endcase
		return m;
	endfunction

	genvar gr;
	generate
		for (gr = 0; gr < REG_COUNT; gr++) begin : g_reg
			localparam logic [15:0] ADDR = REG_FIRST + 16'(gr);
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					cfg_ff[gr] <= pcrb_reset_value(ADDR);
				end else if (reg_wr && in_map && idx == 4'(gr)) begin
					cfg_ff[gr] <= reg_wdata & wr_mask(ADDR);
				end
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reg_rdata <= 16'h0000;
			reg_ack   <= 1'b0;
			reg_err   <= 1'b0;
		end else begin
			reg_ack   <= reg_wr | reg_rd;
			reg_err   <= (reg_wr | reg_rd) & (~in_map | is_reserved);
			if (reg_rd) begin
				reg_rdata <= in_map ? cfg_ff[idx] : 16'h0000;
			end
		end
	end

	logic [15:0] sh_opt1;
	logic [15:0] sh_opt2;
	logic [15:0] hw_opt1;

	assign sh_opt1 = cfg_ff[4'(HEATING_PUMP_DEMAND_OPTIONS - REG_FIRST)];
	assign sh_opt2 = cfg_ff[4'(HEATING_PUMP_OVERRIDE_OPTIONS - REG_FIRST)];
	assign hw_opt1 = cfg_ff[4'(HOT_WATER_PUMP_DEMAND_OPTIONS - REG_FIRST)];

	// ---------------------------------------------------------------
	// one-second tick and day counter
	logic [31:0] tick_cnt_ff;
	logic        sec_tick;
	logic [31:0] day_sec_ff;
	logic [15:0] days_ff;
	logic [15:0] ex_left_ff;
	logic [15:0] ex_interval;
	logic [15:0] ex_duration;

	assign sec_tick    = (tick_cnt_ff == 32'(TICK_CYCLES - 1));
	assign ex_interval = cfg_ff[4'(PUMP_EXERCISE_INTERVAL_DAYS - REG_FIRST)];
	assign ex_duration =
		pcrb_seconds(cfg_ff[4'(PUMP_EXERCISE_DURATION - REG_FIRST)]);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tick_cnt_ff <= 32'h0000_0000;
		end else if (sec_tick) begin
			tick_cnt_ff <= 32'h0000_0000;
		end else begin
			tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
		end
	end

	// idle pumps get a run every interval days; interval 0 disables it
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			day_sec_ff <= 32'h0000_0000;
			days_ff    <= 16'h0000;
			ex_left_ff <= 16'h0000;
		end else if (sec_tick) begin
			if (ex_left_ff != 16'h0000) begin
				ex_left_ff <= ex_left_ff - 16'h0001;
			end
			if (day_sec_ff == 32'(DAY_SECONDS - 1)) begin
				day_sec_ff <= 32'h0000_0000;
				if (ex_interval != 16'h0000 &&
				    days_ff + 16'h0001 >= ex_interval) begin
					days_ff    <= 16'h0000;
					ex_left_ff <= ex_duration;
				end else begin
					days_ff <= days_ff + 16'h0001;
				end
			end else begin
				day_sec_ff <= day_sec_ff + 32'h0000_0001;
			end
		end
	end

	assign exercise_active = (ex_left_ff != 16'h0000);

	// ---------------------------------------------------------------
	// per-role settings: 0 boiler, 1 system, 2 auxiliary 1
	logic [1:0]  role_sel   [NROLE];
	logic        role_force [NROLE];
	logic [15:0] role_dly   [NROLE];
	logic [15:0] role_ovr   [NROLE];

	always_comb begin
		role_sel[0]   = boiler_output_select;
		role_force[0] = s_boiler_forced;
		// [RULE_06] boiler start delay
		role_dly[0]   =
			pcrb_seconds(cfg_ff[4'(BOILER_PUMP_START_DELAY - REG_FIRST)]);
		// [RULE_04] boiler overrun
		role_ovr[0]   =
			pcrb_seconds(cfg_ff[4'(BOILER_PUMP_OVERRUN_TIME - REG_FIRST)]);
		// [RULE_02] control mode
		role_sel[1]   = sel_code(
			cfg_ff[4'(SYSTEM_PUMP_OUTPUT_SELECT - REG_FIRST)]);
		role_force[1] = (cfg_ff[4'(SYSTEM_PUMP_CONTROL_MODE - REG_FIRST)]
			== MODE_FORCED_ON);
		// [RULE_07] system start delay
		role_dly[1]   =
			pcrb_seconds(cfg_ff[4'(SYSTEM_PUMP_START_DELAY - REG_FIRST)]);
		// [RULE_05] system overrun
		role_ovr[1]   =
			pcrb_seconds(cfg_ff[4'(SYSTEM_PUMP_OVERRUN_TIME - REG_FIRST)]);
		role_sel[2]   = sel_code(
			cfg_ff[4'(AUX1_PUMP_OUTPUT_SELECT - REG_FIRST)]);
		role_force[2] = (cfg_ff[4'(AUX1_PUMP_CONTROL_MODE - REG_FIRST)]
			== MODE_FORCED_ON);
		// [RULE_08] auxiliary start delay
		role_dly[2]   =
			pcrb_seconds(cfg_ff[4'(AUX1_PUMP_START_DELAY - REG_FIRST)]);
		// no overrun setting exists for the auxiliary role
		role_ovr[2]   = 16'h0000;
	end

	// [RULE_01] codes above 3 select no output
	function automatic logic [1:0] sel_code(input logic [15:0] v);
		return (v > 16'h0003) ? 2'b00 : v[1:0];
	endfunction

	// ---------------------------------------------------------------
	// role timing machines
	genvar gi;
	generate
		for (gi = 0; gi < NROLE; gi++) begin : g_role
			pcrb_role_state_t st_ff;
			logic [15:0]      cnt_ff;
			logic             want;
			logic             hold;

			assign want = s_role_dem[gi];
			assign hold = role_force[gi] | exercise_active;

			always_ff @(posedge clk) begin
				if (!rst_n) begin
					st_ff  <= PCRB_IDLE;
					cnt_ff <= 16'h0000;
				end else begin
					case (st_ff)
						PCRB_IDLE: begin
							if (hold) begin
								st_ff <= PCRB_RUN;
							end else if (want) begin
								// [RULE_06] start postponed
								if (role_dly[gi] == 16'h0000) begin
									st_ff <= PCRB_RUN;
								end else begin
									st_ff  <= PCRB_DELAY;
									cnt_ff <= role_dly[gi];
								end
							end
						end
						PCRB_DELAY: begin
							if (hold) begin
								st_ff <= PCRB_RUN;
							end else if (!want) begin
								st_ff <= PCRB_IDLE;
							end else if (cnt_ff == 16'h0000) begin
								st_ff <= PCRB_RUN;
							end else if (sec_tick) begin
								cnt_ff <= cnt_ff - 16'h0001;
							end
						end
						PCRB_RUN: begin
							if (!(want | hold)) begin
								// [RULE_04] overrun after demand ends
								if (role_ovr[gi] == 16'h0000) begin
									st_ff <= PCRB_IDLE;
								end else begin
									st_ff  <= PCRB_OVERRUN;
									cnt_ff <= role_ovr[gi];
								end
							end
						end
						PCRB_OVERRUN: begin
							if (want | hold) begin
								st_ff <= PCRB_RUN;
							end else if (cnt_ff == 16'h0000) begin
								st_ff <= PCRB_IDLE;
							end else if (sec_tick) begin
								cnt_ff <= cnt_ff - 16'h0001;
							end
						end
						default: begin
							st_ff <= PCRB_IDLE;
						end
					endcase
				end
			end

			assign role_running[gi] =
				(st_ff == PCRB_RUN) || (st_ff == PCRB_OVERRUN);
		end
	endgenerate

	// [RULE_01] route roles to outputs a..c
	genvar go;
	generate
		for (go = 0; go < 3; go++) begin : g_out
			logic hit;
			always_comb begin
				hit = 1'b0;
				for (int r = 0; r < NROLE; r++) begin
					if (role_running[r] && role_sel[r] == 2'(go + 1)) begin
						hit = 1'b1;
					end
				end
			end
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					pump_out[go] <= 1'b0;
				end else begin
					pump_out[go] <= hit;
				end
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// space-heating and hot-water pump demand from option bitmaps
	function automatic logic opt_demand(input logic [15:0] o,
		input logic [2:0] zyx, input logic hw_svc, input logic sh_svc,
		input logic hw_d, input logic sh_d, input logic loc,
		input logic flt);
		logic d;
		// [RULE_09] auxiliary pump terms
		d = |(o[15:13] & zyx);
		// [RULE_11] service active terms
		d = d | (o[6] & hw_svc) | (o[5] & sh_svc);
		// [RULE_12] demand terms; [RULE_13] fault inhibit
		d = d | (o[3] & hw_d) | (o[2] & sh_d) |
			(o[1] & loc & ~(o[0] & flt));
		return d;
	endfunction

	logic sh_dem;
	logic sh_off;
	logic sh_on;
	logic hw_dem;

	always_comb begin
		// [RULE_14] local demand use gates bitmap demand
		sh_dem = sh_opt2[14] & opt_demand(sh_opt1, s_zyx, s_hw_svc,
			s_sh_svc, s_hw_dem, s_sh_dem, s_local, s_fault);
		// [RULE_16] force-off conditions
		sh_off = |(sh_opt2[8:5] & s_off_cond);
		// [RULE_17] force-on conditions
		sh_on  = |(sh_opt2[4:0] & s_on_cond);
		hw_dem = opt_demand(hw_opt1, s_zyx, s_hw_svc, s_sh_svc,
			s_hw_dem, s_sh_dem, s_local, s_fault);
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			space_heating_pump_on             <= 1'b0;
			domestic_hot_water_pump_on        <= 1'b0;
			space_heating_pump_sequencing_use <= 1'b0;
		end else begin
			// [RULE_18] force-off wins
			space_heating_pump_on <= ~sh_off & (sh_on | sh_dem);
			domestic_hot_water_pump_on <= hw_dem;
			// [RULE_14] sequencing use flag
			space_heating_pump_sequencing_use <= sh_opt2[15];
		end
	end

endmodule // pcrb_top

`default_nettype wire

// ===== pcrb_pkg.sv
// pcrb_pkg: constants and types for the pump configuration register bank.
// assumes a single 200 MHz clock and 16-bit register words.
// Notes on behaviour
// [RULE_01] output select code 0 none, 1..3 route pump to outputs a..c
// [RULE_02] control code 0 lets demand decide, code 1 keeps pump on
// [RULE_03] time registers hold 0..64800 seconds, 0xffff means not configured
// [RULE_04] boiler pump keeps running for its overrun time after demand
// [RULE_05] system pump keeps running for its own overrun time
// [RULE_06] boiler pump start waits its start delay on new demand
// [RULE_07] system pump start waits its own start delay
// [RULE_08] auxiliary 1 pump start waits its own start delay
// [RULE_09] demand bits 15..13 follow auxiliary pump z, y, x
// [RULE_10] demand bits 12..7 and 4 reserved, read as zero
// [RULE_11] bit 6 hot-water service active, bit 5 heating service active
// [RULE_12] bits 3..1 hot-water demand, heating demand, local burner demand
// [RULE_13] bit 0 inhibits local demand while a fault is present
// [RULE_14] override bit 15 sequencing use, bit 14 local demand use
// [RULE_15] override bits 13..9 reserved, always read zero
// [RULE_16] override bits 8..5 force the pump off on listed conditions
// [RULE_17] override bits 4..0 force the pump on on listed conditions
// [RULE_18] force-off wins over force-on and over demand
`default_nettype none

package pcrb_pkg;

	localparam logic [15:0] BOILER_PUMP_OVERRUN_TIME       = 16'h011b;
	localparam logic [15:0] AUX1_PUMP_OUTPUT_SELECT        = 16'h011c;
	localparam logic [15:0] AUX1_PUMP_CONTROL_MODE         = 16'h011d;
	localparam logic [15:0] RESERVED_SLOT                  = 16'h011e;
	localparam logic [15:0] SYSTEM_PUMP_OUTPUT_SELECT      = 16'h011f;
	localparam logic [15:0] SYSTEM_PUMP_CONTROL_MODE       = 16'h0120;
	localparam logic [15:0] SYSTEM_PUMP_OVERRUN_TIME       = 16'h0121;
	localparam logic [15:0] PUMP_EXERCISE_INTERVAL_DAYS    = 16'h0122;
	localparam logic [15:0] PUMP_EXERCISE_DURATION         = 16'h0123;
	localparam logic [15:0] HEATING_PUMP_START_DELAY       = 16'h0124;
	localparam logic [15:0] BOILER_PUMP_START_DELAY        = 16'h0125;
	localparam logic [15:0] SYSTEM_PUMP_START_DELAY        = 16'h0126;
	localparam logic [15:0] AUX1_PUMP_START_DELAY          = 16'h0127;
	localparam logic [15:0] HEATING_PUMP_DEMAND_OPTIONS    = 16'h0128;
	localparam logic [15:0] HEATING_PUMP_OVERRIDE_OPTIONS  = 16'h0129;
	localparam logic [15:0] HOT_WATER_PUMP_DEMAND_OPTIONS  = 16'h012a;

	localparam logic [15:0] REG_FIRST = BOILER_PUMP_OVERRUN_TIME;
	localparam logic [15:0] REG_LAST  = HOT_WATER_PUMP_DEMAND_OPTIONS;
	localparam int          REG_COUNT = 16;

	// writable bits; everything else reads as zero
	localparam logic [15:0] DEMAND_OPT_MASK   = 16'he06f;
	localparam logic [15:0] OVERRIDE_OPT_MASK = 16'hc1ff;

	localparam logic [15:0] RST_TIME    = 16'hffff;
	localparam logic [15:0] RST_SELECT  = 16'h0000;
	localparam logic [15:0] RST_MODE    = 16'h0000;
	localparam logic [15:0] RST_OPTIONS = 16'h0000;
	localparam logic [15:0] RST_DAYS    = 16'h0000;

	localparam logic [15:0] TIME_NOT_CONFIGURED = 16'hffff;
	localparam logic [15:0] TIME_MAX_SECONDS    = 16'hfd20;
	localparam logic [15:0] MODE_FORCED_ON      = 16'h0001;

	localparam int SECOND_NS         = 1000000000;
	localparam int CLK_PERIOD_NS     = 5;
	localparam int CYCLES_PER_SECOND = SECOND_NS / CLK_PERIOD_NS;
	localparam int SECONDS_PER_DAY   = 86400;

	typedef enum logic [1:0] {
		PCRB_IDLE    = 2'b00,
		PCRB_DELAY   = 2'b01,
		PCRB_RUN     = 2'b10,
		PCRB_OVERRUN = 2'b11
	} pcrb_role_state_t;

	function automatic logic [15:0] pcrb_reset_value(input logic [15:0] a);
		logic [15:0] v;
		v = RST_TIME;
		case (a)
			AUX1_PUMP_OUTPUT_SELECT,
			SYSTEM_PUMP_OUTPUT_SELECT:     v = RST_SELECT;
			AUX1_PUMP_CONTROL_MODE,
			SYSTEM_PUMP_CONTROL_MODE:      v = RST_MODE;
			PUMP_EXERCISE_INTERVAL_DAYS:   v = RST_DAYS;
			HEATING_PUMP_DEMAND_OPTIONS,
			HEATING_PUMP_OVERRIDE_OPTIONS,
			HOT_WATER_PUMP_DEMAND_OPTIONS: v = RST_OPTIONS;
			RESERVED_SLOT:                 v = 16'h0000;
			default:                       v = RST_TIME;
		endcase
		return v;
	endfunction

	// [RULE_03] out-of-range or unconfigured time counts as zero
	function automatic logic [15:0] pcrb_seconds(input logic [15:0] t);
		return (t > TIME_MAX_SECONDS) ? 16'h0000 : t;
	endfunction

endpackage

`default_nettype wire

// ===== pcrb_chk.sv
// pcrb_chk: port-level assertions for the pump configuration register bank.
// assumes it is bound onto pcrb_top; one clock, synchronous active-low reset.
`default_nettype none

module pcrb_chk
	import pcrb_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic [15:0] reg_addr,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic        reg_ack,
	input wire logic        reg_err,
	input wire logic        boiler_forced_on,
	input wire logic [2:0]  pump_out,
	input wire logic [2:0]  role_running,
	input wire logic        space_heating_pump_sequencing_use
);
	timeunit 1ns;
	timeprecision 100ps;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_req;
		reg_wr || reg_rd;
	endsequence
	sequence s_opt2_wr;
		reg_wr && reg_addr == HEATING_PUMP_OVERRIDE_OPTIONS;
	endsequence

	property p_ack;
		s_req |=> reg_ack;
	endproperty
	a_ack: assert property (p_ack) else $error("no ack after request");

	property p_no_ack;
		!(reg_wr || reg_rd) |=> !reg_ack && !reg_err;
	endproperty
	a_no_ack: assert property (p_no_ack) else $error("ack without request");

	property p_err_ack;
		reg_err |-> reg_ack;
	endproperty
	a_err_ack: assert property (p_err_ack) else $error("error without ack");

	// read data only moves on a read
	property p_rdata_hold;
		!reg_rd |=> $stable(reg_rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved");

	property p_opt1_rsvd;
		reg_rd && (reg_addr == HEATING_PUMP_DEMAND_OPTIONS ||
			reg_addr == HOT_WATER_PUMP_DEMAND_OPTIONS)
		|=> (reg_rdata & 16'h1f90) == 16'h0000;
	endproperty
	a_opt1_rsvd: assert property (p_opt1_rsvd)
		else $error("reserved demand bits read nonzero");

	property p_opt2_rsvd;
		reg_rd && reg_addr == HEATING_PUMP_OVERRIDE_OPTIONS
		|=> (reg_rdata & 16'h3e00) == 16'h0000;
	endproperty
	a_opt2_rsvd: assert property (p_opt2_rsvd)
		else $error("reserved override bits read nonzero");

	// with no second write right behind, the flag shows the written bit 15 two cycles later
	property p_seq_use;
		s_opt2_wr ##1 !(reg_wr && reg_addr == HEATING_PUMP_OVERRIDE_OPTIONS)
		|-> ##1 space_heating_pump_sequencing_use == $past(reg_wdata[15], 2);
	endproperty
	a_seq_use: assert property (p_seq_use)
		else $error("sequencing use flag wrong");

	property p_forced;
		boiler_forced_on [*4] |-> role_running[0];
	endproperty
	a_forced: assert property (p_forced)
		else $error("forced boiler pump not running");

	property p_out;
		pump_out != 3'b000 |-> $past(role_running) != 3'b000;
	endproperty
	a_out: assert property (p_out)
		else $error("output on with no role running");
endmodule // pcrb_chk

bind pcrb_top pcrb_chk i_pcrb_chk (
	.clk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
	.reg_ack, .reg_err, .boiler_forced_on, .pump_out, .role_running,
	.space_heating_pump_sequencing_use
);

`default_nettype wire

// ===== pcrb_master.sv
// pcrb_master: register master standing in for the remote panel.
// assumes the one-cycle strobe and next-cycle ack of the register port.
`default_nettype none

module pcrb_master (
	input  wire logic        clk,
	output var  logic [15:0] reg_addr,
	output var  logic        reg_wr,
	output var  logic        reg_rd,
	output var  logic [15:0] reg_wdata,
	input  wire logic [15:0] reg_rdata,
	input  wire logic        reg_ack,
	input  wire logic        reg_err
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		reg_addr = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 16'h0000;
	end

	// called at a rising edge; returns at a rising edge
	task automatic xfer(input logic we, input logic [15:0] a, d,
		output logic [15:0] q, output logic e);
		int n;
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= we;
		reg_rd <= ~we;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		// released lines must not keep looking valid
		reg_addr <= ~a;
		reg_wdata <= ~d;
		n = 0;
		#1;
		while (reg_ack !== 1'b1 && n < 4) begin
			@(posedge clk);
			#1;
			n++;
		end
		q = reg_rdata;
		e = (reg_ack === 1'b1) ? reg_err : 1'bx;
		@(posedge clk);
	endtask
endmodule // pcrb_master

`default_nettype wire

// ===== tb_pump_config_register_bank.sv
// tb_pump_config_register_bank: register sweep, pump roles, option pumps.
// assumes pcrb_top with a 10-cycle second; checker attached by bind.
`default_nettype none

module tb_pump_config_register_bank
	import pcrb_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int T = 10;

	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [15:0] reg_addr, reg_wdata, reg_rdata;
	logic        reg_wr, reg_rd, reg_ack, reg_err;
	logic [1:0]  sel_b = 2'd1;
	logic        forced = 1'b0;
	logic [2:0]  dem = 3'b000;
	logic [16:0] cond = '0;
	logic [2:0]  pump_out, role_running;
	logic        sh_on, hw_on, ex_on;
	int          fails = 0;
	int          num_checks = 0;

	always #2.5 clk = ~clk;

	pcrb_top #(.TICK_CYCLES(T), .DAY_SECONDS(3)) i_pcrb_top (
		.clk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
		.reg_ack, .reg_err, .boiler_output_select(sel_b),
		.boiler_forced_on(forced), .boiler_demand(dem[0]),
		.system_demand(dem[1]), .aux1_demand(dem[2]),
		.aux_pump_zyx(cond[16:14]),
		.domestic_hot_water_service(cond[0]),
		.space_heating_service(cond[1]),
		.domestic_hot_water_demand(cond[2]),
		.space_heating_demand(cond[3]), .local_burner_demand(cond[4]),
		.fault_present(cond[5]), .domestic_hot_water_high_limit(cond[6]),
		.domestic_hot_water_anti_cond(cond[7]),
		.space_heating_anti_cond(cond[8]),
		.domestic_hot_water_priority(cond[9]),
		.domestic_hot_water_frost(cond[10]),
		.space_heating_frost(cond[11]),
		.sequencing_slave_demand(cond[12]),
		.outlet_high_limit(cond[13]), .pump_out, .role_running,
		.space_heating_pump_on(sh_on), .domestic_hot_water_pump_on(hw_on),
		.space_heating_pump_sequencing_use(), .exercise_active(ex_on)
	);

	pcrb_master i_pcrb_master (
		.clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
		.reg_ack, .reg_err
	);

	task automatic summarize();
		if (fails == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] exp, got);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [15:0] a, d);
		logic [15:0] q;
		logic        e;
		i_pcrb_master.xfer(1'b1, a, d, q, e);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	function automatic logic [15:0] rst_val(input logic [15:0] a);
		case (a)
			BOILER_PUMP_OVERRUN_TIME, SYSTEM_PUMP_OVERRUN_TIME,
			PUMP_EXERCISE_DURATION, HEATING_PUMP_START_DELAY,
			BOILER_PUMP_START_DELAY, SYSTEM_PUMP_START_DELAY,
			AUX1_PUMP_START_DELAY: return 16'hffff;
			default: return 16'h0000;
		endcase
	endfunction

	function automatic logic [15:0] keep(input logic [15:0] a);
		if (a > REG_LAST || a == RESERVED_SLOT)
			return 16'h0000;
		case (a)
			HEATING_PUMP_DEMAND_OPTIONS: return 16'he06f;
			HOT_WATER_PUMP_DEMAND_OPTIONS: return 16'he06f;
			HEATING_PUMP_OVERRIDE_OPTIONS: return 16'hc1ff;
			default: return 16'hffff;
		endcase
	endfunction

	// demand d seconds late, overrun o seconds (o < 0: none)
	task automatic role(input int r, input logic [15:0] ad, ao,
		input int d, o);
		wr(ad, 16'(d));
		if (o >= 0)
			wr(ao, 16'(o));
		dem[r] <= 1'b1;
		cyc((d - 1) * T + 1);
		@(negedge clk);
		chk("early start", 16'h0, {15'h0, role_running[r]});
		cyc(2 * T + 4);
		@(negedge clk);
		chk("pump out", 16'(3'b001 << r), {13'h0, pump_out});
		@(posedge clk);
		dem[r] <= 1'b0;
		if (o > 0) begin
			cyc((o - 1) * T + 1);
			@(negedge clk);
			chk("overrun", 16'h1, {15'h0, role_running[r]});
			cyc(T + 6);
		end else
			cyc(6);
		@(negedge clk);
		chk("stopped", 16'h0, {13'h0, pump_out});
		@(posedge clk);
	endtask

	// {demand opts, override opts, hot water opts, pins, {hw, sh}}
	localparam logic [66:0] STEPS [9] = '{
		{16'h0000, 16'h0002, 16'h0000, 17'h00010, 2'b01},
		{16'h0004, 16'h4000, 16'h0008, 17'h0000c, 2'b11},
		{16'h0004, 16'h4040, 16'h0008, 17'h0010c, 2'b10},
		{16'h0000, 16'h0008, 16'h0000, 17'h00800, 2'b01},
		{16'h0003, 16'h4000, 16'h0000, 17'h00010, 2'b01},
		{16'h0003, 16'h4000, 16'h0000, 17'h00030, 2'b00},
		{16'h8000, 16'h4000, 16'h0000, 17'h10000, 2'b01},
		{16'h0040, 16'h4000, 16'h0020, 17'h00003, 2'b11},
		{16'h0004, 16'h0000, 16'h0000, 17'h00008, 2'b00}
	};

	initial begin
		logic [15:0] a, q, o1, o2, h1;
		logic [16:0] c;
		logic [1:0]  x;
		logic        e;
		cyc(2);
		rst_n <= 1'b1;
		cyc(1);
		for (int i = 0; i <= 16; i++) begin
			a = REG_FIRST + 16'(i);
			i_pcrb_master.xfer(1'b0, a, 16'h0000, q, e);
			chk("reset value", rst_val(a), q);
			chk("refusal", {15'h0, keep(a) == 16'h0000}, {15'h0, e});
			wr(a, 16'hffff);
			i_pcrb_master.xfer(1'b0, a, 16'h0000, q, e);
			chk("readback", keep(a), q);
		end
		// mid-run reset brings back the defaults
		rst_n <= 1'b0;
		cyc(2);
		rst_n <= 1'b1;
		cyc(1);
		i_pcrb_master.xfer(1'b0, BOILER_PUMP_OVERRUN_TIME, 16'h0000, q, e);
		chk("reset again", 16'hffff, q);
		wr(SYSTEM_PUMP_OUTPUT_SELECT, 16'h0002);
		wr(AUX1_PUMP_OUTPUT_SELECT, 16'h0003);
		role(0, BOILER_PUMP_START_DELAY, BOILER_PUMP_OVERRUN_TIME, 2, 2);
		role(1, SYSTEM_PUMP_START_DELAY, SYSTEM_PUMP_OVERRUN_TIME, 3, 3);
		role(2, AUX1_PUMP_START_DELAY, AUX1_PUMP_START_DELAY, 2, -1);
		foreach (STEPS[i]) begin
			{o1, o2, h1, c, x} = STEPS[i];
			wr(HEATING_PUMP_DEMAND_OPTIONS, o1);
			wr(HEATING_PUMP_OVERRIDE_OPTIONS, o2);
			wr(HOT_WATER_PUMP_DEMAND_OPTIONS, h1);
			cond <= c;
			cyc(5);
			@(negedge clk);
			chk("option pumps", {14'h0, x}, {14'h0, hw_on, sh_on});
			@(posedge clk);
		end
		wr(AUX1_PUMP_CONTROL_MODE, MODE_FORCED_ON);
		cyc(4);
		@(negedge clk);
		chk("forced aux", 16'h0004, {13'h0, pump_out});
		@(posedge clk);
		wr(AUX1_PUMP_CONTROL_MODE, 16'h0000);
		cyc(6);
		forced <= 1'b1;
		cyc(6);
		@(negedge clk);
		chk("forced boiler", 16'h0001, {13'h0, pump_out});
		@(posedge clk);
		forced <= 1'b0;
		cyc(6);
		wr(PUMP_EXERCISE_DURATION, 16'h0002);
		wr(PUMP_EXERCISE_INTERVAL_DAYS, 16'h0001);
		// exercise runs 20 of every 30 cycles here, so watch a window
		e = 1'b0;
		repeat (40) begin
			@(negedge clk);
			e = e | (ex_on === 1'b1 && pump_out === 3'b111);
		end
		chk("exercise", 16'h0001, {15'h0, e});
		@(posedge clk);
		wr(PUMP_EXERCISE_INTERVAL_DAYS, 16'h0000);
		cyc(40);
		@(negedge clk);
		chk("exercise off", 16'h0000, {15'h0, ex_on});
		@(posedge clk);
		summarize();
	end

	// run needs about 550 cycles
	initial begin
		#(20000 * 5);
		fails++;
		summarize();
	end
endmodule // tb_pump_config_register_bank

`default_nettype wire
